/* hdl/analog_current_output_control.v */
// The implementer's own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/100ps
`include "aoc_consts.vh"
module analog_current_output_control (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [11:0] s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [11:0] s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire [127:0] feedback_code,
	input  wire [7:0]  relay_position,
	input  wire [15:0] pack_temperature,
	input  wire [3:0]  selftest_ok,
	input  wire        identity_match,
	input  wire        application_ok,
	input  wire [1:0]  supply_ok,
	output reg  [127:0] dac_code,
	output reg         dac_load,
	output reg  [7:0]  relay_close,
	output reg         diag_indication,
	output reg         link_ok_indication,
	output reg         attention_indication,
	output reg         irq
);

	// ==========================================================
	// Startup and frame timing
	// ==========================================================
	localparam ST_TEST = 2'h0;
	localparam ST_ID   = 2'h1;
	localparam ST_RUN  = 2'h2;
	localparam ST_FAIL = 2'h3;

	reg  [1:0]  state_r;
	reg  [19:0] frame_cnt_r;
	reg         frame_tick_r;
	reg  [3:0]  dith_cnt_r;
	reg  [7:0]  dith_phase_r;

	// Self-test, then identity check, before running
	always @(posedge aclk) begin
		if (!aresetn)
			state_r <= ST_TEST;
		else
			case (state_r)
			ST_TEST: state_r <= (&selftest_ok) ? ST_ID : ST_TEST;
			ST_ID:   state_r <= (identity_match && application_ok) ? ST_RUN : ST_FAIL;
			ST_RUN:  state_r <= ST_RUN;
			default: state_r <= ST_FAIL;
			endcase
	end

	// Frame strobe at 100 Hz; dither phase steps once per frame
	always @(posedge aclk) begin
		if (!aresetn) begin
			frame_cnt_r  <= 20'h00000;
			frame_tick_r <= 1'b0;
			dith_phase_r <= 8'h00;
		end else if (frame_cnt_r == `FRAME_LAST) begin
			frame_cnt_r  <= 20'h00000;
			frame_tick_r <= 1'b1;
			dith_phase_r <= dith_phase_r + 8'h01;
		end else begin
			frame_cnt_r  <= frame_cnt_r + 20'h00001;
			frame_tick_r <= 1'b0;
		end
	end

	// ==========================================================
	// Register file
	// ==========================================================
	reg  [31:0] ctrl_r;
	reg  [31:0] preset_r;
	reg  [7:0]  irq_stat_r;
	reg  [7:0]  irq_mask_r;
	reg  [31:0] cfg_r   [0:7];
	reg  [15:0] low_eu_r  [0:7];
	reg  [15:0] high_eu_r [0:7];
	reg  [31:0] setpt_r [0:7];
	reg  [15:0] cmd_r   [0:7];
	reg  [15:0] held_r  [0:7];
	reg  [7:0]  diag_r;
	reg         aw_got_r;
	reg         w_got_r;
	reg  [11:0] awaddr_r;
	reg  [31:0] wdata_r;

	// Per-channel decode, shared by read and write paths
	function [3:0] ch_of;
		input [11:0] a;
		begin
			ch_of = (a[11:8] == 4'h1) ? {1'b1, a[7:5]} : 4'h0;
		end
	endfunction

	// Address and data may arrive in either order
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_r      <= 1'b0;
			w_got_r       <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			awaddr_r      <= 12'h000;
			wdata_r       <= 32'h00000000;
		end else begin
			s_axi_awready <= !aw_got_r && !s_axi_awready && s_axi_awvalid && !s_axi_bvalid;
			s_axi_wready  <= !w_got_r && !s_axi_wready && s_axi_wvalid && !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_r <= 1'b1;
				wdata_r <= s_axi_wdata;
			end
			if (aw_got_r && w_got_r) begin
				aw_got_r <= 1'b0;
				w_got_r  <= 1'b0;
			end
		end
	end

	wire        wr_go = aw_got_r && w_got_r;
	wire [3:0]  wr_ch = ch_of(awaddr_r);
	wire [2:0]  wr_ix = awaddr_r[4:2];
	wire [7:0]  irq_ev;
	integer     i, j, m;

	// Register writes; byte strobes ignored, full word writes assumed
	always @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r       <= 32'h00000000;
			preset_r     <= 32'h00000000;
			irq_mask_r   <= 8'h00;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'h0;
			for (j = 0; j < `NCH; j = j + 1) begin
				cfg_r[j]     <= 32'h00000000;
				low_eu_r[j]  <= 16'h0000;
				high_eu_r[j] <= 16'hFFFF;
				setpt_r[j]   <= 32'hFFFF0000;
				cmd_r[j]     <= 16'h0000;
			end
		end else begin
			ctrl_r[`F_DIAG_CLR] <= 1'b0;
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= 2'h0;
				if (awaddr_r == `REG_CTRL)
					ctrl_r <= wdata_r;
				else if (awaddr_r == `REG_IRQ_MASK)
					irq_mask_r <= wdata_r[7:0];
				else if (awaddr_r == `REG_PRESET)
					preset_r <= wdata_r;
				else if (awaddr_r == `REG_IRQ_STAT || awaddr_r == `REG_STATUS
					|| awaddr_r == `REG_TEMP)
					s_axi_bresp <= 2'h0;
				else if (wr_ch[3] && wr_ix == `CH_CFG)
					cfg_r[wr_ch[2:0]] <= wdata_r;
				else if (wr_ch[3] && wr_ix == `CH_LOW_EU)
					low_eu_r[wr_ch[2:0]] <= wdata_r[15:0];
				else if (wr_ch[3] && wr_ix == `CH_HIGH_EU)
					high_eu_r[wr_ch[2:0]] <= wdata_r[15:0];
				else if (wr_ch[3] && wr_ix == `CH_SETPT)
					setpt_r[wr_ch[2:0]] <= wdata_r;
				else if (wr_ch[3] && wr_ix == `CH_CMD)
					cmd_r[wr_ch[2:0]] <= wdata_r[15:0];
				else
					s_axi_bresp <= 2'h2;
			end
		end
	end

	// Sticky events; a new event outranks a write-one clear
	always @(posedge aclk) begin
		if (!aresetn)
			irq_stat_r <= 8'h00;
		else if (wr_go && awaddr_r == `REG_IRQ_STAT)
			irq_stat_r <= (irq_stat_r & ~wdata_r[7:0]) | irq_ev;
		else
			irq_stat_r <= irq_stat_r | irq_ev;
	end

	// ==========================================================
	// Per-channel datapath
	// ==========================================================
	wire        link_ok  = ctrl_r[`F_LINK_OK];
	wire        running  = (state_r == ST_RUN);
	reg  [15:0] meas_r  [0:7];
	reg  [7:0]  unhealthy_now;
	reg  [7:0]  mismatch_now;
	reg  [7:0]  relay_fault_now;
	reg  [7:0]  fault_now;
	reg  [7:0]  relay_nxt;
	reg  [127:0] code_nxt;
	reg  [15:0] lo_sp;
	reg  [15:0] hi_sp;
	reg  [15:0] cmd_eff;
	reg  [15:0] fb;
	reg  [16:0] span_eu;
	reg  [33:0] lin;
	reg  [31:0] scaled;
	reg  [31:0] dith;
	reg  [31:0] outv;
	reg  [16:0] diff;
	reg  [23:0] limit;
	reg         dith_sign;
	reg         cmd_bad;

	// Dither on-frame selection by rate code
	function dither_high;
		input [3:0] sel;
		input [7:0] ph;
		begin
			case (sel)
			4'h1:    dither_high = ph[2];        // 12.5 Hz
			4'h2:    dither_high = ph[1];        // 25 Hz
			4'h3:    dither_high = (ph % 8'h03) == 8'h00; // about 33.33 Hz
			4'h4:    dither_high = ph[0];        // 50 Hz square
			4'h5:    dither_high = ph[0];        // Frame rate caps this at alternation
			default: dither_high = 1'b0;
			endcase
		end
	endfunction

	always @* begin
		code_nxt        = 128'h0;
		relay_nxt       = 8'h00;
		unhealthy_now   = 8'h00;
		mismatch_now    = 8'h00;
		relay_fault_now = 8'h00;
		fault_now       = 8'h00;
		lo_sp = 16'h0; hi_sp = 16'h0; cmd_eff = 16'h0; fb = 16'h0;
		span_eu = 17'h0; lin = 34'h0; scaled = 32'h0; dith = 32'h0;
		outv = 32'h0; diff = 17'h0; limit = 24'h0; dith_sign = 1'b0; cmd_bad = 1'b0;
		for (i = 0; i < `NCH; i = i + 1) begin
			lo_sp = setpt_r[i][15:0];
			hi_sp = setpt_r[i][31:16];
			// Offline: hold last or use preset; open-zero handled at relay
			if (!link_ok && cfg_r[i][3:2] == `OFFL_HOLD_LAST)
				cmd_eff = held_r[i];
			else if (!link_ok && cfg_r[i][3:2] == `OFFL_PRESET)
				cmd_eff = preset_r[15:0];
			else
				cmd_eff = cmd_r[i];
			cmd_bad = (low_eu_r[i] < high_eu_r[i]) ?
				(cmd_eff < low_eu_r[i] || cmd_eff > high_eu_r[i]) : 1'b0;
			span_eu = {1'b0, high_eu_r[i]} - {1'b0, low_eu_r[i]};
			// Linear map; inverted spans yield low setpoint
			if (span_eu[16] || span_eu == 17'h0 || cmd_eff <= low_eu_r[i])
				scaled = {16'h0, lo_sp};
			else if (cmd_eff >= high_eu_r[i])
				scaled = {16'h0, hi_sp};
			else begin
				lin = {18'h0, cmd_eff - low_eu_r[i]} * ({18'h0, hi_sp} - {18'h0, lo_sp});
				scaled = {16'h0, lo_sp} + lin[31:0] / {15'h0, span_eu};
			end
			// Dither: amplitude percent capped at 10
			dith = (scaled * ((cfg_r[i][15:8] > 8'd10) ? 32'd10 : {24'h0, cfg_r[i][15:8]}))
				/ 32'd100;
			dith_sign = dither_high(cfg_r[i][7:4], dith_phase_r);
			if (cfg_r[i][7:4] == 4'h0)
				outv = scaled;
			else if (dith_sign)
				outv = scaled + dith;
			else
				outv = (dith > scaled) ? 32'h0 : scaled - dith;
			if (outv > `CODE_20MA_32)
				outv = `CODE_20MA_32;
			fb = feedback_code[i*16 +: 16];
			diff = (fb > scaled[15:0]) ? {1'b0, fb - scaled[15:0]} : {1'b0, scaled[15:0] - fb};
			limit = ({8'h0, `CODE_20MA} * {16'h0, (cfg_r[i][23:16] > 8'd100) ?
				8'd100 : cfg_r[i][23:16]}) / 24'd100;
			mismatch_now[i]  = cfg_r[i][`F_RANGE] && ({7'h0, diff} > limit);
			unhealthy_now[i] = cfg_r[i][`F_RANGE] && (cmd_bad || fb == 16'hFFFF);
			fault_now[i]     = mismatch_now[i] | unhealthy_now[i];
			// Relay closed when running, enabled, linked or not open-zero, no disconnect
			relay_nxt[i] = running && cfg_r[i][`F_RANGE]
				&& (link_ok || cfg_r[i][3:2] != `OFFL_OPEN_ZERO)
				&& !(cfg_r[i][`F_DISC] && fault_now[i]);
			relay_fault_now[i] = relay_close[i] != relay_position[i];
			if (relay_nxt[i])
				code_nxt[i*16 +: 16] = outv[15:0];
		end
	end

	// Frame refresh of codes and relays; snapshot of last command
	always @(posedge aclk) begin
		if (!aresetn) begin
			dac_code    <= 128'h0;
			dac_load    <= 1'b0;
			relay_close <= 8'h00;
			for (m = 0; m < `NCH; m = m + 1) begin
				held_r[m] <= 16'h0000;
				meas_r[m] <= 16'h0000;
			end
		end else begin
			dac_load <= frame_tick_r;
			if (frame_tick_r) begin
				dac_code    <= code_nxt;
				relay_close <= relay_nxt;
				for (m = 0; m < `NCH; m = m + 1) begin
					meas_r[m] <= feedback_code[m*16 +: 16];
					if (link_ok)
						held_r[m] <= cmd_r[m];
				end
			end
		end
	end

	// ==========================================================
	// Diagnostics, latching and indications
	// ==========================================================
	wire [7:0] cond_now = mismatch_now | unhealthy_now | relay_fault_now;
	wire       supply_bad = !(&supply_ok);
	reg        supply_diag_r;

	// Latched when enabled; clear request frees only healthy bits
	always @(posedge aclk) begin
		if (!aresetn) begin
			diag_r        <= 8'h00;
			supply_diag_r <= 1'b0;
		end else if (ctrl_r[`F_LATCH]) begin
			diag_r        <= (ctrl_r[`F_DIAG_CLR] ? (diag_r & cond_now) : diag_r)
				| cond_now;
			supply_diag_r <= (ctrl_r[`F_DIAG_CLR] ? 1'b0 : supply_diag_r)
				| supply_bad;
		end else begin
			diag_r        <= cond_now;
			supply_diag_r <= supply_bad;
		end
	end

	assign irq_ev = cond_now & ~diag_r;

	// Outputs for status reporting and interrupt
	always @(posedge aclk) begin
		if (!aresetn) begin
			diag_indication      <= 1'b0;
			link_ok_indication   <= 1'b0;
			attention_indication <= 1'b0;
			irq                  <= 1'b0;
		end else begin
			diag_indication      <= (|diag_r) | supply_diag_r;
			link_ok_indication   <= link_ok;
			attention_indication <= (state_r == ST_FAIL) || !running;
			irq                  <= |(irq_stat_r & irq_mask_r);
		end
	end

	// ==========================================================
	// Read path
	// ==========================================================
	wire [3:0] rd_ch = ch_of(s_axi_araddr);
	wire [2:0] rd_ix = s_axi_araddr[4:2];

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= 2'h0;
		end else begin
			s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
			if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= 2'h0;
				if (s_axi_araddr == `REG_CTRL)
					s_axi_rdata <= ctrl_r;
				else if (s_axi_araddr == `REG_STATUS)
					s_axi_rdata <= {8'h0, relay_close, diag_r, 3'h0, supply_diag_r,
						link_ok, state_r, running};
				else if (s_axi_araddr == `REG_IRQ_STAT)
					s_axi_rdata <= {24'h0, irq_stat_r};
				else if (s_axi_araddr == `REG_IRQ_MASK)
					s_axi_rdata <= {24'h0, irq_mask_r};
				else if (s_axi_araddr == `REG_TEMP)
					s_axi_rdata <= {16'h0, pack_temperature};
				else if (s_axi_araddr == `REG_PRESET)
					s_axi_rdata <= preset_r;
				else if (rd_ch[3] && rd_ix == `CH_CFG)
					s_axi_rdata <= cfg_r[rd_ch[2:0]];
				else if (rd_ch[3] && rd_ix == `CH_LOW_EU)
					s_axi_rdata <= {16'h0, low_eu_r[rd_ch[2:0]]};
				else if (rd_ch[3] && rd_ix == `CH_HIGH_EU)
					s_axi_rdata <= {16'h0, high_eu_r[rd_ch[2:0]]};
				else if (rd_ch[3] && rd_ix == `CH_SETPT)
					s_axi_rdata <= setpt_r[rd_ch[2:0]];
				else if (rd_ch[3] && rd_ix == `CH_CMD)
					s_axi_rdata <= {16'h0, cmd_r[rd_ch[2:0]]};
				else if (rd_ch[3] && rd_ix == `CH_MEAS)
					s_axi_rdata <= {15'h0, relay_position[rd_ch[2:0]],
						meas_r[rd_ch[2:0]]};
				else begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= 2'h2;
				end
			end
		end
	end

endmodule // analog_current_output_control

/* hdl/aoc_consts.vh */
// Behaviour
// - Refresh all eight channel current codes once per 100 Hz frame.
// - Per-channel range select: unused disables channel, 0-20 mA enables it.
// - Linear map: low engineering value to low setpoint, high to high setpoint.
// - Flag mismatch when feedback differs from command beyond percent threshold.
// - Disconnect enabled: open relay of faulty channel; else relay as commanded.
// - Relay fault whenever commanded relay state disagrees with position feedback.
// - Link loss applies offline mode: open and zero, hold last, or preset.
// - Superimpose dither, amplitude 0 to 10 percent of scaled current.
// - Dither rate selectable: unused, 12.5, 25, 33.33, 50, 100 Hz (the 100 Hz code toggles once per frame, giving 50 Hz).
// - Diagnostics individually latchable (one CTRL latch bit covers all of them); clear request clears only healthy ones.
// - Power-up self-test of RAM, flash, network ports, processor before run.
// - Board identities must match as a set, then application must suit set.
// - Monitor internal supplies; report status fault on a bad supply.
// - Report diag, link ok, attention, temperature, per-channel relay and current.
// - Per-channel feedback-unhealthy alarm on out-of-range command or feedback.
`ifndef AOC_CONSTS_VH
`define AOC_CONSTS_VH
`define CLK_HZ          100000000
`define FRAME_HZ        100
`define FRAME_CYC       (`CLK_HZ / `FRAME_HZ)
`define FRAME_LAST      20'hF423F
`define NCH             8
// Register byte offsets
`define REG_CTRL        12'h000
`define REG_STATUS      12'h004
`define REG_IRQ_STAT    12'h008
`define REG_IRQ_MASK    12'h00C
`define REG_TEMP        12'h010
`define REG_PRESET      12'h014
`define REG_CH_BASE     12'h100
`define CH_STRIDE_SH    5
// Per-channel word indices within a 32-byte slot
`define CH_CFG          3'h0
`define CH_LOW_EU       3'h1
`define CH_HIGH_EU      3'h2
`define CH_SETPT        3'h3
`define CH_CMD          3'h4
`define CH_MEAS         3'h5
// CH_CFG fields
`define F_RANGE         0
`define F_DISC          1
`define F_OFFL_LO       2
`define F_DFREQ_LO      4
`define F_DAMP_LO       8
`define F_ERRTH_LO      16
// CTRL fields
`define F_LINK_OK       0
`define F_DIAG_CLR      1
`define F_LATCH         2
// Offline modes
`define OFFL_OPEN_ZERO  2'h0
`define OFFL_HOLD_LAST  2'h1
`define OFFL_PRESET     2'h2
// Full scale code of 20 mA
`define CODE_20MA       16'hFFFF
`define CODE_20MA_32    32'h0000FFFF
`endif

/* testbench/aoc_front_end_model.sv */
`timescale 1ns/100ps
// ======================================
// Analog front end: converter, sense resistor and relays
module aoc_front_end_model (
	input  logic [127:0] dac_code,
	input  logic [7:0]   relay_close,
	input  logic [7:0]   stuck_closed,
	output logic [127:0] feedback_code,
	output logic [7:0]   relay_position
);
	genvar g;
	// Open relay breaks the loop, so no current is sensed
	generate
		for (g = 0; g < 8; g = g + 1) begin : ch
			assign feedback_code[16*g+:16] = relay_close[g] ? dac_code[16*g+:16] : 16'h0000;
		end
	endgenerate
	// Welded contact injection lets the bench force a disagreement
	assign relay_position = relay_close | stuck_closed;
endmodule // aoc_front_end_model

/* testbench/aoc_monitor.sv */
`timescale 1ns/100ps
// ======================================
// Port timing checks for the current output controller
module aoc_monitor (
	input logic         aclk,
	input logic         aresetn,
	input logic         s_axi_awvalid,
	input logic         s_axi_awready,
	input logic         s_axi_wvalid,
	input logic         s_axi_wready,
	input logic [1:0]   s_axi_bresp,
	input logic         s_axi_bvalid,
	input logic         s_axi_bready,
	input logic         s_axi_arvalid,
	input logic         s_axi_arready,
	input logic [31:0]  s_axi_rdata,
	input logic         s_axi_rvalid,
	input logic         s_axi_rready,
	input logic [127:0] dac_code,
	input logic         dac_load,
	input logic [7:0]   relay_close
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Responses stand until the master takes them
	write_resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	read_data_hold_a: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data changed before taken");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:3] s_axi_bvalid) else $error("write answer late");
	addr_accept_a: assert property ($rose(s_axi_awvalid) && !s_axi_bvalid |=> s_axi_awready)
		else $error("write address not accepted");
	// Converter and relays change only on the frame strobe
	frame_pulse_a: assert property (dac_load |=> !dac_load [*8])
		else $error("frame strobe too long");
	code_on_frame_a: assert property ($changed(dac_code) |-> dac_load)
		else $error("converter code changed off frame");
	relay_on_frame_a: assert property ($changed(relay_close) |-> dac_load)
		else $error("relay command changed off frame");
endmodule // aoc_monitor
bind analog_current_output_control aoc_monitor mon (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.dac_code(dac_code), .dac_load(dac_load), .relay_close(relay_close));

/* testbench/analog_current_output_control_test.sv */
`timescale 1ns/100ps
`include "aoc_consts.vh"
// ======================================
// Register level bench for the current output controller
module analog_current_output_control_test;
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; $display("unexpected %s exp %h got %h", nm, e, g); end end
	localparam [11:0] CH2 = `REG_CH_BASE + (12'h2 << `CH_STRIDE_SH);
	localparam [11:0] CH3 = `REG_CH_BASE + (12'h3 << `CH_STRIDE_SH);
	reg          aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, id_ok, app_ok;
	reg  [11:0]  awaddr, araddr;
	reg  [31:0]  wdata, d, v;
	reg  [15:0]  temp;
	reg  [3:0]   selftest;
	reg  [1:0]   supply, r;
	reg  [7:0]   stuck;
	wire         awready, wready, bvalid, arready, rvalid, dac_load, diag_ind, link_ind, attn, irq;
	wire [1:0]   bresp, rresp;
	wire [31:0]  rdata;
	wire [127:0] dac_code, feedback_code;
	wire [7:0]   relay_close, relay_position;
	integer      n_mismatch, comparisons, i, n;
	// Free running 100 MHz clock
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	analog_current_output_control dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.feedback_code(feedback_code), .relay_position(relay_position),
		.pack_temperature(temp), .selftest_ok(selftest), .identity_match(id_ok),
		.application_ok(app_ok), .supply_ok(supply), .dac_code(dac_code), .dac_load(dac_load),
		.relay_close(relay_close), .diag_indication(diag_ind), .link_ok_indication(link_ind),
		.attention_indication(attn), .irq(irq));
	aoc_front_end_model fe (.dac_code(dac_code), .relay_close(relay_close),
		.stuck_closed(stuck), .feedback_code(feedback_code), .relay_position(relay_position));
	// Verdict and end of run
	task finish_test;
		begin
			if (n_mismatch == 0 && comparisons > 0)
				$display("Run complete: PASS");
			else
				$display("Run complete: FAIL");
			$finish;
		end
	endtask
	// One cycle of a bounded wait; running out ends the run
	task step;
		begin
			@(posedge aclk);
			n = n + 1;
			if (n > 200) begin
				n_mismatch++;
				finish_test;
			end
		end
	endtask
	task rst;
		begin
			aresetn <= 1'b0;
			repeat (5) @(posedge aclk);
			aresetn <= 1'b1;
			@(posedge aclk);
		end
	endtask
	// Address and data offered together, each released when taken
	task wr(input [11:0] a, input [31:0] val);
		begin
			@(posedge aclk);
			awaddr <= a;
			wdata <= val;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
			n = 0;
			do begin
				step;
				if (awready) awvalid <= 1'b0;
				if (wready) wvalid <= 1'b0;
			end while (!bvalid);
			r = bresp;
			bready <= 1'b0;
		end
	endtask
	task rd(input [11:0] a);
		begin
			@(posedge aclk);
			araddr <= a;
			arvalid <= 1'b1;
			rready <= 1'b1;
			n = 0;
			do begin
				step;
				if (arready) arvalid <= 1'b0;
			end while (!rvalid);
			d = rdata;
			r = rresp;
			rready <= 1'b0;
		end
	endtask
	task chk(input [11:0] a, input [31:0] e);
		begin
			rd(a);
			`CHK("register", e, d)
		end
	endtask
	// Status fields settle a few cycles after their cause
	task poll(input [11:0] a, input [31:0] m, input [31:0] e);
		integer k;
		begin
			k = 0;
			rd(a);
			while (((d & m) !== e) && k < 40) begin
				rd(a);
				k++;
			end
			`CHK("status field", e, d & m)
		end
	endtask
	// Main sequence
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = 0;
		{temp, selftest, id_ok, app_ok, supply, stuck} = {16'h1234, 4'hF, 1'b1, 1'b1, 2'h3, 8'h00};
		n_mismatch = 0;
		comparisons = 0;
		rst;
		`CHK("relay_close", 8'h00, relay_close)
		chk(`REG_IRQ_STAT, 32'h00000000);
		chk(`REG_IRQ_MASK, 32'h00000000);
		poll(`REG_STATUS, 32'h00000001, 32'h00000001);
		chk(`REG_TEMP, 32'h00001234);
		for (i = 0; i < 6; i++) begin
			v = {8'h00, 8'(i * 20), 8'(i * 2), i[3:0], 2'(i % 3), 2'b10};
			wr(CH3, v);
			chk(CH3, v);
		end
		wr(CH3 + 12'h004, 32'hFFFFFC18);
		chk(CH3 + 12'h004, 32'h0000FC18);
		wr(CH3 + 12'h00C, 32'hFFFF0000);
		chk(CH3 + 12'h00C, 32'hFFFF0000);
		wr(CH3 + 12'h010, 32'h00004000);
		chk(CH3 + 12'h010, 32'h00004000);
		wr(`REG_PRESET, 32'h00008000);
		chk(`REG_PRESET, 32'h00008000);
		// Unmapped place refuses both ways
		wr(12'h0F0, 32'hA5A5A5A5);
		`CHK("write resp", 2'h2, r)
		rd(12'h0F0);
		`CHK("read resp", 2'h2, r)
		`CHK("read data", 32'h00000000, d)
		wr(`REG_CTRL, 32'h00000005);
		n = 0;
		while (link_ind !== 1'b1) step;
		`CHK("link_ok", 1'b1, link_ind)
		supply <= 2'h1;
		poll(`REG_STATUS, 32'h00000010, 32'h00000010);
		supply <= 2'h3;
		wr(`REG_CTRL, 32'h00000007);
		poll(`REG_STATUS, 32'h00000010, 32'h00000000);
		// Welded relay on channel 2, with latching on
		wr(`REG_IRQ_MASK, 32'hFFFFFFFF);
		`CHK("irq", 1'b0, irq)
		stuck <= 8'h04;
		poll(`REG_STATUS, 32'h00000400, 32'h00000400);
		rd(CH2 + 12'h014);
		`CHK("relay position", 1'b1, d[16])
		n = 0;
		while (irq !== 1'b1) step;
		`CHK("irq", 1'b1, irq)
		rd(`REG_IRQ_STAT);
		wr(`REG_IRQ_STAT, d);
		poll(`REG_IRQ_STAT, 32'hFFFFFFFF, 32'h00000000);
		`CHK("irq", 1'b0, irq)
		wr(`REG_CTRL, 32'h00000007);
		poll(`REG_STATUS, 32'h00000400, 32'h00000400);
		stuck <= 8'h00;
		repeat (10) @(posedge aclk);
		poll(`REG_STATUS, 32'h00000400, 32'h00000400);
		wr(`REG_CTRL, 32'h00000007);
		poll(`REG_STATUS, 32'h00000400, 32'h00000000);
		// Channel 3 enabled with a command below its low engineering value
		wr(CH3, 32'h00000001);
		poll(`REG_STATUS, 32'h00000800, 32'h00000800);
		// In range now, but no sensed current against a zero threshold
		wr(CH3 + 12'h010, 32'h0000FE00);
		wr(`REG_CTRL, 32'h00000007);
		poll(`REG_STATUS, 32'h00000800, 32'h00000800);
		// Full threshold tolerates the gap, so the clear succeeds
		wr(CH3, 32'h00640001);
		wr(`REG_CTRL, 32'h00000007);
		poll(`REG_STATUS, 32'h00000800, 32'h00000000);
		// Failed power-up checks keep the outputs parked
		selftest <= 4'h7;
		rst;
		repeat (20) @(posedge aclk);
		poll(`REG_STATUS, 32'h00000001, 32'h00000000);
		selftest <= 4'hF;
		id_ok <= 1'b0;
		rst;
		n = 0;
		while (attn !== 1'b1) step;
		`CHK("attention", 1'b1, attn)
		poll(`REG_STATUS, 32'h00000007, 32'h00000006);
		id_ok <= 1'b1;
		app_ok <= 1'b0;
		rst;
		n = 0;
		while (attn !== 1'b1) step;
		`CHK("attention", 1'b1, attn)
		poll(`REG_STATUS, 32'h00000007, 32'h00000006);
		`CHK("relay_close", 8'h00, relay_close)
		finish_test;
	end
endmodule // analog_current_output_control_test
